// ---- core/gpio_sel_pkg.sv ----
`default_nettype none

package gpio_sel_pkg;

	// System clock
	localparam int unsigned CLOCK_PERIOD_NS = 4;

	// Accessory event pulse length on the pin
	localparam int unsigned ACC_PULSE_TIME_NS = 31000;
	localparam int unsigned ACC_PULSE_CYCLES = ACC_PULSE_TIME_NS / CLOCK_PERIOD_NS;
	localparam int unsigned PULSE_CNT_WIDTH = 16;

	// Derived output clock: half period in system clock cycles
	localparam int unsigned DERIVED_OUTPUT_CLOCK_HALF_CYCLES = 4;
	localparam int unsigned DIV_CNT_WIDTH = 16;

	// Register port
	localparam int unsigned ADDR_WIDTH = 4;
	localparam int unsigned DATA_WIDTH = 32;
	localparam logic [3:0] OFF_CONFIG = 4'h0;
	localparam logic [3:0] OFF_STATUS = 4'h4;

	// Config register fields
	localparam int unsigned FN_LSB = 0;
	localparam int unsigned FN_WIDTH = 5;
	localparam int unsigned DIR_BIT = 5;
	localparam int unsigned LVL_BIT = 6;

	// Status register fields
	localparam int unsigned STAT_PIN_IN_BIT = 0;
	localparam int unsigned STAT_PIN_OUT_BIT = 1;
	localparam int unsigned STAT_PULSE_BIT = 2;
	localparam int unsigned STAT_DERIVED_OUTPUT_CLOCK_BIT = 3;

	// Reset values: pin starts as an input, code 0
	localparam logic [4:0] FN_RESET = 5'h00;
	localparam logic DIR_RESET = 1'h1;
	localparam logic LVL_RESET = 1'h0;

	// Function codes
	localparam logic [4:0] FN_LOGIC_LEVEL = 5'h01;
	localparam logic [4:0] FN_ACC_DETECT = 5'h05;
	localparam logic [4:0] FN_FLL1_LOCK = 5'h09;
	localparam logic [4:0] FN_FLL2_LOCK = 5'h0A;
	localparam logic [4:0] FN_SRC1_LOCK = 5'h0B;
	localparam logic [4:0] FN_SRC2_LOCK = 5'h0C;
	localparam logic [4:0] FN_DRC1_DETECT = 5'h0D;
	localparam logic [4:0] FN_DRC2_DETECT = 5'h0F;
	localparam logic [4:0] FN_FIFO_ERROR = 5'h11;
	localparam logic [4:0] FN_DERIVED_OUTPUT_CLOCK = 5'h12;
	localparam logic [4:0] FN_TEMP_WARN = 5'h13;
	localparam logic [4:0] FN_DC_SERVO = 5'h14;
	localparam logic [4:0] FN_FLL1_CLOCK = 5'h15;
	localparam logic [4:0] FN_FLL2_CLOCK = 5'h16;

	// Synchroniser lanes
	localparam int unsigned SYNC_WIDTH = 3;
	localparam int unsigned SYNC_PIN = 0;
	localparam int unsigned SYNC_FLL1 = 1;
	localparam int unsigned SYNC_FLL2 = 2;

endpackage

`default_nettype wire

// ---- core/gpio_status_output_select.sv ----
`timescale 1ns/1ns
`default_nettype none

module gpio_status_output_select #(
	parameter int unsigned ACC_PULSE_CYCLES = gpio_sel_pkg::ACC_PULSE_CYCLES,
	parameter int unsigned DERIVED_OUTPUT_CLOCK_HALF_CYCLES = gpio_sel_pkg::DERIVED_OUTPUT_CLOCK_HALF_CYCLES
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Register port
	input wire logic [gpio_sel_pkg::ADDR_WIDTH-1:0] reg_addr,
	input wire logic [gpio_sel_pkg::DATA_WIDTH-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [gpio_sel_pkg::DATA_WIDTH-1:0] reg_rdata,
	// Internal status sources, system clock domain
	input wire logic accessory_event,
	input wire logic fll1_lock,
	input wire logic fll2_lock,
	input wire logic src1_lock,
	input wire logic src2_lock,
	input wire logic first_audio_port_drc_detect,
	input wire logic second_audio_port_drc_detect,
	input wire logic fifo_error,
	input wire logic temp_warning,
	input wire logic dc_servo_left_done,
	input wire logic dc_servo_right_done,
	// Loop clocks from other domains
	input wire logic fll1_clock,
	input wire logic fll2_clock,
	// General-purpose pin
	input wire logic pin_in,
	output logic pin_out,
	output logic pin_oe_n
);

	generate
		if (ACC_PULSE_CYCLES < 1 || ACC_PULSE_CYCLES >= (1 << gpio_sel_pkg::PULSE_CNT_WIDTH)) begin : g_bad_pulse
			$error("ACC_PULSE_CYCLES out of range");
		end
		if (DERIVED_OUTPUT_CLOCK_HALF_CYCLES < 1 || DERIVED_OUTPUT_CLOCK_HALF_CYCLES >= (1 << gpio_sel_pkg::DIV_CNT_WIDTH)) begin : g_bad_div
			$error("DERIVED_OUTPUT_CLOCK_HALF_CYCLES out of range");
		end
	endgenerate

	localparam logic [gpio_sel_pkg::PULSE_CNT_WIDTH-1:0] PULSE_LOAD =
		gpio_sel_pkg::PULSE_CNT_WIDTH'(ACC_PULSE_CYCLES);
	localparam logic [gpio_sel_pkg::DIV_CNT_WIDTH-1:0] DIV_LAST =
		gpio_sel_pkg::DIV_CNT_WIDTH'(DERIVED_OUTPUT_CLOCK_HALF_CYCLES - 1);

	typedef struct packed {
		logic [gpio_sel_pkg::FN_WIDTH-1:0] func;
		logic dir;
		logic level;
		logic [gpio_sel_pkg::SYNC_WIDTH-1:0] sync1;
		logic [gpio_sel_pkg::SYNC_WIDTH-1:0] sync2;
		logic [gpio_sel_pkg::PULSE_CNT_WIDTH-1:0] pulse_cnt;
		logic [gpio_sel_pkg::DIV_CNT_WIDTH-1:0] div_cnt;
		logic derived_output_clock;
		logic pin_out;
		logic pin_oe_n;
		logic [gpio_sel_pkg::DATA_WIDTH-1:0] rdata;
	} state_t;

	localparam state_t STATE_RESET = '{
		func: gpio_sel_pkg::FN_RESET,
		dir: gpio_sel_pkg::DIR_RESET,
		level: gpio_sel_pkg::LVL_RESET,
		sync1: '0,
		sync2: '0,
		pulse_cnt: '0,
		div_cnt: '0,
		derived_output_clock: 1'h0,
		pin_out: 1'h0,
		pin_oe_n: 1'h1,
		rdata: '0
	};

	state_t state;
	state_t next_state;
	logic selected;
	logic [gpio_sel_pkg::DATA_WIDTH-1:0] read_value;

	function automatic logic hits(input logic [gpio_sel_pkg::ADDR_WIDTH-1:0] addr,
			input logic [gpio_sel_pkg::ADDR_WIDTH-1:0] offset);
		hits = (addr == offset);
	endfunction

	always_comb begin
		next_state = state;
		selected = 1'h0;
		read_value = '0;

		// Loop clocks and the pin come from outside this domain
		next_state.sync1 = {fll2_clock, fll1_clock, pin_in};
		next_state.sync2 = state.sync1;

		if (reg_write && hits(reg_addr, gpio_sel_pkg::OFF_CONFIG)) begin
			next_state.func = reg_wdata[gpio_sel_pkg::FN_LSB +: gpio_sel_pkg::FN_WIDTH];
			next_state.dir = reg_wdata[gpio_sel_pkg::DIR_BIT];
			next_state.level = reg_wdata[gpio_sel_pkg::LVL_BIT];
		end

		// A new event restarts the pulse, so two close events stretch into one
		if (accessory_event) begin
			next_state.pulse_cnt = PULSE_LOAD;
		end else if (state.pulse_cnt != '0) begin
			next_state.pulse_cnt = state.pulse_cnt - 1'b1;
		end

		// Free-running divider, so the clock stays glitch-free when selected
		if (state.div_cnt == DIV_LAST) begin
			next_state.div_cnt = '0;
			next_state.derived_output_clock = ~state.derived_output_clock;
		end else begin
			next_state.div_cnt = state.div_cnt + 1'b1;
		end

		case (state.func)
			gpio_sel_pkg::FN_LOGIC_LEVEL: selected = state.level;
			gpio_sel_pkg::FN_ACC_DETECT: selected = (state.pulse_cnt != '0);
			gpio_sel_pkg::FN_FLL1_LOCK: selected = fll1_lock;
			gpio_sel_pkg::FN_FLL2_LOCK: selected = fll2_lock;
			gpio_sel_pkg::FN_SRC1_LOCK: selected = src1_lock;
			gpio_sel_pkg::FN_SRC2_LOCK: selected = src2_lock;
			gpio_sel_pkg::FN_DRC1_DETECT: selected = first_audio_port_drc_detect;
			gpio_sel_pkg::FN_DRC2_DETECT: selected = second_audio_port_drc_detect;
			gpio_sel_pkg::FN_FIFO_ERROR: selected = fifo_error;
			gpio_sel_pkg::FN_DERIVED_OUTPUT_CLOCK: selected = state.derived_output_clock;
			gpio_sel_pkg::FN_TEMP_WARN: selected = temp_warning;
			// Done only when both channels have finished
			gpio_sel_pkg::FN_DC_SERVO: selected = dc_servo_left_done & dc_servo_right_done;
			// Sampled at the system clock: loop clocks must stay well below half of it
			gpio_sel_pkg::FN_FLL1_CLOCK: selected = state.sync2[gpio_sel_pkg::SYNC_FLL1];
			gpio_sel_pkg::FN_FLL2_CLOCK: selected = state.sync2[gpio_sel_pkg::SYNC_FLL2];
			default: selected = 1'h0;
		endcase

		// Input mode releases the pin and drives low behind the enable
		next_state.pin_out = state.dir ? 1'h0 : selected;
		next_state.pin_oe_n = state.dir;

		read_value[gpio_sel_pkg::FN_LSB +: gpio_sel_pkg::FN_WIDTH] = '0;
		if (hits(reg_addr, gpio_sel_pkg::OFF_CONFIG)) begin
			read_value[gpio_sel_pkg::FN_LSB +: gpio_sel_pkg::FN_WIDTH] = state.func;
			read_value[gpio_sel_pkg::DIR_BIT] = state.dir;
			read_value[gpio_sel_pkg::LVL_BIT] = state.level;
		end else if (hits(reg_addr, gpio_sel_pkg::OFF_STATUS)) begin
			read_value[gpio_sel_pkg::STAT_PIN_IN_BIT] = state.sync2[gpio_sel_pkg::SYNC_PIN];
			read_value[gpio_sel_pkg::STAT_PIN_OUT_BIT] = state.pin_out;
			read_value[gpio_sel_pkg::STAT_PULSE_BIT] = (state.pulse_cnt != '0);
			read_value[gpio_sel_pkg::STAT_DERIVED_OUTPUT_CLOCK_BIT] = state.derived_output_clock;
		end
		// Read data only stand in the cycle after the strobe
		next_state.rdata = reg_read ? read_value : '0;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= STATE_RESET;
		end else begin
			state <= next_state;
		end
	end

	assign pin_out = state.pin_out;
	assign pin_oe_n = state.pin_oe_n;
	assign reg_rdata = state.rdata;

	// Checks
	logic out_mode;
	logic [gpio_sel_pkg::PULSE_CNT_WIDTH-1:0] high_run;

	assign out_mode = !state.dir;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			high_run <= '0;
		end else if (pin_out && state.func == gpio_sel_pkg::FN_ACC_DETECT) begin
			high_run <= high_run + 1'b1;
		end else begin
			high_run <= '0;
		end
	end

	sequence s_acc_trigger;
		accessory_event && out_mode && state.func == gpio_sel_pkg::FN_ACC_DETECT ##1
			out_mode && state.func == gpio_sel_pkg::FN_ACC_DETECT;
	endsequence

	property p_acc_pulse_start;
		@(posedge clock) disable iff (!rst_n)
		s_acc_trigger |=> pin_out;
	endproperty
	a_acc_pulse_start: assert property (p_acc_pulse_start) else $error("accessory pulse did not start");

	property p_acc_pulse_len;
		@(posedge clock) disable iff (!rst_n)
		high_run <= PULSE_LOAD;
	endproperty
	a_acc_pulse_len: assert property (p_acc_pulse_len) else $error("accessory pulse too long");

	property p_fll1_lock;
		@(posedge clock) disable iff (!rst_n)
		(out_mode && state.func == gpio_sel_pkg::FN_FLL1_LOCK) |=> (pin_out == $past(fll1_lock));
	endproperty
	a_fll1_lock: assert property (p_fll1_lock) else $error("pin does not follow loop 1 lock");

	property p_fll2_lock;
		@(posedge clock) disable iff (!rst_n)
		(out_mode && state.func == gpio_sel_pkg::FN_FLL2_LOCK && fll2_lock) |=> pin_out;
	endproperty
	a_fll2_lock: assert property (p_fll2_lock) else $error("pin low while loop 2 locked");

	property p_src1_lock;
		@(posedge clock) disable iff (!rst_n)
		(out_mode && state.func == gpio_sel_pkg::FN_SRC1_LOCK && !src1_lock) |=> !pin_out;
	endproperty
	a_src1_lock: assert property (p_src1_lock) else $error("pin high while converter 1 unlocked");

	property p_src2_lock;
		@(posedge clock) disable iff (!rst_n)
		(out_mode && state.func == gpio_sel_pkg::FN_SRC2_LOCK) |=> (pin_out == $past(src2_lock));
	endproperty
	a_src2_lock: assert property (p_src2_lock) else $error("pin does not follow converter 2 lock");

	property p_drc1;
		@(posedge clock) disable iff (!rst_n)
		(out_mode && state.func == gpio_sel_pkg::FN_DRC1_DETECT)
			|=> (pin_out == $past(first_audio_port_drc_detect));
	endproperty
	a_drc1: assert property (p_drc1) else $error("pin does not follow port 1 detect");

	property p_drc2;
		@(posedge clock) disable iff (!rst_n)
		(out_mode && state.func == gpio_sel_pkg::FN_DRC2_DETECT)
			|=> (pin_out == $past(second_audio_port_drc_detect));
	endproperty
	a_drc2: assert property (p_drc2) else $error("pin does not follow port 2 detect");

	property p_fifo;
		@(posedge clock) disable iff (!rst_n)
		(out_mode && state.func == gpio_sel_pkg::FN_FIFO_ERROR) |=> (pin_out == $past(fifo_error));
	endproperty
	a_fifo: assert property (p_fifo) else $error("pin does not follow FIFO error");

	property p_temp;
		@(posedge clock) disable iff (!rst_n)
		(out_mode && state.func == gpio_sel_pkg::FN_TEMP_WARN) |=> (pin_out == $past(temp_warning));
	endproperty
	a_temp: assert property (p_temp) else $error("pin does not follow temperature warning");

	property p_servo;
		@(posedge clock) disable iff (!rst_n)
		(out_mode && state.func == gpio_sel_pkg::FN_DC_SERVO)
			|=> (pin_out == ($past(dc_servo_left_done) && $past(dc_servo_right_done)));
	endproperty
	a_servo: assert property (p_servo) else $error("pin does not show servo completion");

	property p_input_mode;
		@(posedge clock) disable iff (!rst_n)
		state.dir |=> (pin_oe_n && !pin_out);
	endproperty
	a_input_mode: assert property (p_input_mode) else $error("pin driven in input mode");

	property p_reserved;
		@(posedge clock) disable iff (!rst_n)
		(out_mode && (state.func inside {5'h06, 5'h07, 5'h08, 5'h0E, 5'h10}))
			|=> (!pin_out && !pin_oe_n);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved code drives pin high");

	property p_acc_select;
		@(posedge clock) disable iff (!rst_n)
		(out_mode && state.func == gpio_sel_pkg::FN_ACC_DETECT)
			|=> (pin_out == ($past(state.pulse_cnt) != '0));
	endproperty
	a_acc_select: assert property (p_acc_select) else $error("pin does not show the accessory pulse");

	property p_derived_output_clock_select;
		@(posedge clock) disable iff (!rst_n)
		(out_mode && state.func == gpio_sel_pkg::FN_DERIVED_OUTPUT_CLOCK) |=> (pin_out == $past(state.derived_output_clock));
	endproperty
	a_derived_output_clock_select: assert property (p_derived_output_clock_select) else $error("pin does not carry the derived clock");

	// Changing only where the divider wraps is what fixes the half period
	property p_derived_output_clock_toggle;
		@(posedge clock) disable iff (!rst_n)
		(state.div_cnt == DIV_LAST) |=> (state.derived_output_clock != $past(state.derived_output_clock));
	endproperty
	a_derived_output_clock_toggle: assert property (p_derived_output_clock_toggle) else $error("derived clock missed its edge");

	property p_derived_output_clock_hold;
		@(posedge clock) disable iff (!rst_n)
		(state.div_cnt != DIV_LAST) |=> $stable(state.derived_output_clock);
	endproperty
	a_derived_output_clock_hold: assert property (p_derived_output_clock_hold) else $error("derived clock changed mid half period");

	property p_fll1_clock;
		@(posedge clock) disable iff (!rst_n)
		(out_mode && state.func == gpio_sel_pkg::FN_FLL1_CLOCK)
			|=> (pin_out == $past(state.sync2[gpio_sel_pkg::SYNC_FLL1]));
	endproperty
	a_fll1_clock: assert property (p_fll1_clock) else $error("pin does not carry loop 1 clock");

	property p_fll2_clock;
		@(posedge clock) disable iff (!rst_n)
		(out_mode && state.func == gpio_sel_pkg::FN_FLL2_CLOCK)
			|=> (pin_out == $past(state.sync2[gpio_sel_pkg::SYNC_FLL2]));
	endproperty
	a_fll2_clock: assert property (p_fll2_clock) else $error("pin does not carry loop 2 clock");

	property p_output_mode;
		@(posedge clock) disable iff (!rst_n)
		out_mode |=> !pin_oe_n;
	endproperty
	a_output_mode: assert property (p_output_mode) else $error("pin not driven in output mode");

	// A lingering word would look like the answer to the next read
	property p_rdata_idle;
		@(posedge clock) disable iff (!rst_n)
		!reg_read |=> (reg_rdata == '0);
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data stand beyond one cycle");

endmodule // gpio_status_output_select

`default_nettype wire

// ---- tb/pin_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module pin_host_model (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Pin as the host sees it
	input wire logic pin_out,
	input wire logic pin_oe_n,
	input wire logic host_drive,
	input wire logic host_level,
	output logic pin_level,
	// Length of the last completed high run, in clock cycles
	output logic [15:0] high_run
);
	logic [15:0] run;
	// Pull-up keeps the wire high when neither side drives it
	assign pin_level = !pin_oe_n ? pin_out : (host_drive ? host_level : 1'b1);
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			run <= 16'h0000;
			high_run <= 16'h0000;
		end else if (pin_level) begin
			run <= run + 16'h0001;
		end else begin
			if (run != 16'h0000) begin
				high_run <= run;
			end
			run <= 16'h0000;
		end
	end
endmodule // pin_host_model
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	localparam int ACC = 8;
	localparam int HALF = 4;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h00000000;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [31:0] reg_rdata;
	logic accessory_event = 1'b0;
	logic [9:0] src = 10'h000;
	logic fll1_clock = 1'b0;
	logic fll2_clock = 1'b0;
	logic host_drive = 1'b1;
	logic host_level = 1'b0;
	logic pin_level, pin_out, pin_oe_n;
	logic [15:0] high_run;
	logic [31:0] d;
	logic [4:0] codes [9] = '{5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0F, 5'h11, 5'h13, 5'h14};
	logic [4:0] rsv [5] = '{5'h06, 5'h07, 5'h08, 5'h0E, 5'h10};
	int num_errors = 0;
	int checks = 0;

	always #2 clock = ~clock;

	gpio_status_output_select #(.ACC_PULSE_CYCLES(ACC), .DERIVED_OUTPUT_CLOCK_HALF_CYCLES(HALF)) dut_u (
		.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.accessory_event(accessory_event), .fll1_lock(src[0]), .fll2_lock(src[1]),
		.src1_lock(src[2]), .src2_lock(src[3]), .first_audio_port_drc_detect(src[4]),
		.second_audio_port_drc_detect(src[5]), .fifo_error(src[6]), .temp_warning(src[7]),
		.dc_servo_left_done(src[8]), .dc_servo_right_done(src[9]), .fll1_clock(fll1_clock),
		.fll2_clock(fll2_clock), .pin_in(pin_level), .pin_out(pin_out), .pin_oe_n(pin_oe_n)
	);

	pin_host_model host_u (
		.clock(clock), .rst_n(rst_n), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.host_drive(host_drive), .host_level(host_level), .pin_level(pin_level), .high_run(high_run)
	);

	task automatic complete_run();
		if (num_errors == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask

	// Read data stand for one cycle only, so the following cycle is checked for zero
	task automatic rd(input logic [3:0] a);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		@(negedge clock);
		d = reg_rdata;
		@(negedge clock);
		chk("rdata idle", reg_rdata, 32'h00000000);
	endtask

	task automatic cfg(input logic [4:0] code, input logic dir, input logic lvl);
		wr(4'h0, {25'h0000000, lvl, dir, code});
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clock);
		@(negedge clock);
	endtask

	initial begin
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		settle(1);
		chk("oe after reset", {31'h0, pin_oe_n}, 32'h00000001);
		rd(4'h0);
		chk("config reset", d, 32'h00000020);
		wr(4'h4, 32'h0000001F);
		rd(4'h0);
		chk("status write ignored", d, 32'h00000020);
		rd(4'h8);
		chk("unmapped read", d, 32'h00000000);
		// Pin as input: status drive stays off and the host level is seen
		@(posedge clock);
		src <= 10'h3FF;
		cfg(5'h09, 1'b1, 1'b0);
		settle(4);
		chk("input oe", {30'h0, pin_oe_n, pin_out}, 32'h00000002);
		rd(4'h4);
		chk("status pin low", {31'h0, d[0]}, 32'h00000000);
		@(posedge clock);
		host_level <= 1'b1;
		settle(4);
		rd(4'h4);
		chk("status pin high", {31'h0, d[0]}, 32'h00000001);
		cfg(5'h01, 1'b0, 1'b1);
		settle(3);
		chk("logic level out", {31'h0, pin_level}, 32'h00000001);
		// Each status code follows only its own source; servo needs both sides
		for (int i = 0; i < 9; i++) begin
			cfg(codes[i], 1'b0, 1'b0);
			@(posedge clock);
			src <= (i == 8) ? 10'h1FF : ~(10'h001 << i);
			settle(3);
			chk("status low", {30'h0, pin_oe_n, pin_level}, 32'h00000000);
			@(posedge clock);
			src <= (i == 8) ? 10'h300 : (10'h001 << i);
			settle(3);
			chk("status high", {31'h0, pin_level}, 32'h00000001);
		end
		@(posedge clock);
		src <= 10'h200;
		settle(3);
		chk("servo left pending", {31'h0, pin_level}, 32'h00000000);
		@(posedge clock);
		src <= 10'h3FF;
		for (int i = 0; i < 5; i++) begin
			cfg(rsv[i], 1'b0, 1'b1);
			settle(3);
			chk("reserved code", {31'h0, pin_level}, 32'h00000000);
		end
		// Loop clocks: each code carries its own loop, the other held opposite
		for (int k = 0; k < 2; k++) begin
			cfg(5'h15 + 5'(k), 1'b0, 1'b0);
			for (int v = 1; v >= 0; v--) begin
				@(posedge clock);
				fll1_clock <= (k == 0) ? v[0] : ~v[0];
				fll2_clock <= (k == 0) ? ~v[0] : v[0];
				settle(6);
				chk("loop clock", {31'h0, pin_level}, {31'h0, v[0]});
			end
		end
		cfg(5'h12, 1'b0, 1'b0);
		settle(30);
		chk("derived clock half period", {16'h0, high_run}, HALF);
		cfg(5'h05, 1'b0, 1'b0);
		settle(2);
		chk("no event no pulse", {31'h0, pin_level}, 32'h00000000);
		@(posedge clock);
		accessory_event <= 1'b1;
		@(posedge clock);
		accessory_event <= 1'b0;
		settle(3);
		chk("pulse started", {31'h0, pin_level}, 32'h00000001);
		rd(4'h4);
		chk("status in pulse", {29'h0, d[2:0]}, 32'h00000007);
		for (int n = 0; n < 50 && pin_level; n++) begin
			@(negedge clock);
		end
		if (pin_level) begin
			num_errors++;
		end
		settle(1);
		chk("pulse length", {16'h0, high_run}, ACC);
		// Reset in mid-run releases a driven pin and restores the input setting
		cfg(5'h13, 1'b0, 1'b0);
		@(posedge clock);
		rst_n <= 1'b0;
		settle(2);
		chk("oe in reset", {30'h0, pin_oe_n, pin_out}, 32'h00000002);
		@(posedge clock);
		rst_n <= 1'b1;
		settle(1);
		chk("oe after release", {30'h0, pin_oe_n, pin_out}, 32'h00000002);
		rd(4'h0);
		chk("config after reset", d, 32'h00000020);
		complete_run();
	end
endmodule // tb_top
`default_nettype wire
